// file: sar_adc_pkg.sv
// Notes on behaviour
// RULE1 - Writing one to start bit begins conversion; bit clears itself once started.
// RULE2 - Bit 4 of first control gates analog inputs; one disables them.
// RULE3 - Channel field resets reserved; codes 0010 to 0101 pick the four inputs.
// RULE4 - Software changes channel only while busy flag reads zero.
// RULE5 - Software writes one to bit 5, zero to bit 6 of first control.
// RULE6 - Software never restarts during a conversion; waits for end flag or interrupt.
// RULE7 - STOP mode resets both control registers and ignores writes to them.
// RULE8 - Ladder bit one connects reference ladder only while converting.
// RULE9 - Time field codes 010, 011, 100 give 78, 156, 312 fc cycles.
// RULE10 - Software writes zero to bit 0, one to bit 4 of second control.
// RULE11 - Bits 7 and 6 of second control read undefined; here zero.
// RULE12 - Result register holds eight-bit value, resets to zero.
// RULE13 - End flag reads zero before or during conversion, one once completed.
// RULE14 - Reading result clears end flag; software reads status first.
// RULE15 - Busy flag rises at start, falls at finish or STOP entry.
// RULE16 - Status bits other than busy and end read unstable; here zero.
// RULE17 - Software avoids pin output instructions while a conversion runs.
// RULE18 - Completion stores result, sets end flag, raises interrupt together.
// RULE19 - Count selected cycles, approximate MSB first, signal completion at count end.
package sar_adc_pkg;

    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 8;
    localparam int          CNT_W        = 9;
    localparam int          IRQ_W        = 2;

    // Register offsets
    localparam logic [7:0]  OFS_CTRL1    = 8'h0e;
    localparam logic [7:0]  OFS_CTRL2    = 8'h0f;
    localparam logic [7:0]  OFS_RESULT   = 8'h20;
    localparam logic [7:0]  OFS_STATUS   = 8'h21;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h22;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h23;

    // Reset values
    localparam logic [7:0]  RST_CTRL1    = 8'h10;
    localparam logic [7:0]  RST_CTRL2    = 8'h10;
    localparam logic [7:0]  RST_RESULT   = 8'h00;
    localparam logic [1:0]  RST_IRQ      = 2'h0;

    // Field positions
    localparam int          START_BIT    = 7;
    localparam int          GATE_BIT     = 4;
    localparam int          CH_LSB       = 0;
    localparam int          LADDER_BIT   = 5;
    localparam int          TIME_LSB     = 1;
    localparam int          EOC_BIT      = 5;
    localparam int          BUSY_BIT     = 4;
    localparam int          IRQ_DONE     = 0;
    localparam int          IRQ_REFUSED  = 1;

    // Channel and time codes
    localparam logic [3:0]  CH_FIRST     = 4'h2;
    localparam logic [3:0]  CH_LAST      = 4'h5;
    localparam logic [2:0]  TIME_SHORT   = 3'h2;
    localparam logic [2:0]  TIME_MID     = 3'h3;
    localparam logic [2:0]  TIME_LONG    = 3'h4;

    // Conversion times in fc periods, and clock cycles per fc period
    localparam int          CONV_FC_SHORT = 78;
    localparam int          CONV_FC_MID   = 156;
    localparam int          CONV_FC_LONG  = 312;
    localparam int          MCLK_PER_FC   = 1;
    localparam logic [8:0]  CYC_SHORT    = CNT_W'(CONV_FC_SHORT * MCLK_PER_FC);
    localparam logic [8:0]  CYC_MID      = CNT_W'(CONV_FC_MID * MCLK_PER_FC);
    localparam logic [8:0]  CYC_LONG     = CNT_W'(CONV_FC_LONG * MCLK_PER_FC);
    localparam logic [8:0]  SAMPLE_MIN   = 9'h006;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_TRIAL} sar_state_t;

    // Reserved time codes fall back to the longest time
    function automatic logic [8:0] conv_cycles(input logic [2:0] code);
        case (code)
            TIME_SHORT: conv_cycles = CYC_SHORT;
            TIME_MID:   conv_cycles = CYC_MID;
            default:    conv_cycles = CYC_LONG;
        endcase
    endfunction

endpackage

// file: sar_adc_props_properties.sv
`timescale 1ns/1ps
module sar_adc_props
    import sar_adc_pkg::*;
(
    // Clock and reset
    input wire logic                            i_mclk,
    input wire logic                            i_rst,
    // Inputs
    input wire logic                            i_stop,
    input wire logic [sar_adc_pkg::ADDR_W-1:0]  i_addr,
    input wire logic [sar_adc_pkg::DATA_W-1:0]  i_wdata,
    input wire logic                            i_wr,
    input wire logic                            i_rd,
    input wire logic                            i_cmp,
    // Outputs
    input wire logic [sar_adc_pkg::DATA_W-1:0]  o_rdata,
    input wire logic                            o_irq,
    input wire logic [3:0]                      o_channel,
    input wire logic                            o_input_gate_off,
    input wire logic                            o_ladder_on,
    input wire logic                            o_sample,
    input wire logic [7:0]                      o_dac_code,
    input wire logic                            o_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_start_busy: assert property (
        i_wr && i_addr == OFS_CTRL1 && i_wdata[START_BIT] && !o_busy && !i_stop
        ##1 !i_stop ##1 !i_stop |-> o_busy)
        else $error("busy did not follow start");
    a_stop_idle: assert property (i_stop |=> !o_busy)
        else $error("busy kept in stop");
    a_stop_clear: assert property (
        i_stop ##1 i_stop |-> o_channel == 4'h0 && o_input_gate_off && !o_ladder_on)
        else $error("control not reset in stop");
    a_status_bits: assert property (
        $past(i_rd && i_addr == OFS_STATUS) |-> (o_rdata & 8'hcf) == 8'h00)
        else $error("status spare bits set");
    a_ctrl2_bits: assert property (
        $past(i_rd && i_addr == OFS_CTRL2) |-> o_rdata[7:6] == 2'h0)
        else $error("ctrl2 top bits set");
    a_busy_bound: assert property ($rose(o_busy) |-> ##[1:312] !o_busy)
        else $error("conversion too long");
    a_busy_hold: assert property ($rose(o_busy) ##0 !i_stop [*8] |-> o_busy)
        else $error("conversion too short");
    a_ladder_busy: assert property (o_busy |-> o_ladder_on)
        else $error("ladder off while busy");
endmodule

bind sar_adc_register_control sar_adc_props props_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_stop(i_stop), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_cmp(i_cmp), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_channel(o_channel), .o_input_gate_off(o_input_gate_off), .o_ladder_on(o_ladder_on),
    .o_sample(o_sample), .o_dac_code(o_dac_code), .o_busy(o_busy));

// file: sar_adc_register_control.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module sar_adc_register_control (
    // Clock and reset
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    // Power mode
    input  wire logic                          i_stop,
    // Register port
    input  wire logic [sar_adc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sar_adc_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic [sar_adc_pkg::DATA_W-1:0]     o_rdata,
    // Interrupt
    output logic                               o_irq,
    // Analog front end
    input  wire logic                          i_cmp,
    output logic [3:0]                         o_channel,
    output logic                               o_input_gate_off,
    output logic                               o_ladder_on,
    output logic                               o_sample,
    output logic [7:0]                         o_dac_code,
    output logic                               o_busy
);
    import sar_adc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]       ctrl1_q,    ctrl1_d;
    logic [7:0]       ctrl2_q,    ctrl2_d;
    logic             start_q,    start_d;
    logic [7:0]       result_q,   result_d;
    logic             eoc_q,      eoc_d;
    logic [IRQ_W-1:0] istat_q,    istat_d;
    logic [IRQ_W-1:0] imask_q,    imask_d;
    logic [7:0]       rdata_q,    rdata_d;
    logic             irq_q,      irq_d;
    logic             ladder_q,   ladder_d;
    logic             eng_busy;
    logic             eng_samp;
    logic             eng_done;
    logic [7:0]       eng_result;
    logic [7:0]       eng_trial;
    logic             wr_ctrl1;
    logic             wr_ctrl2;
    logic             start_req;
    logic             refused;
    logic [IRQ_W-1:0] ev_set;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Strobe aimed at one register offset
    function automatic logic reg_hit(input logic              strobe,
                                     input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Conversion engine

    sar_engine u_engine (
        .i_mclk     (i_mclk),
        .i_rst      (i_rst),
        .i_start    (start_q),
        .i_abort    (i_stop),
        .i_total    (conv_cycles(ctrl2_q[TIME_LSB +: 3])),
        .i_cmp      (i_cmp),
        .o_busy     (eng_busy),
        .o_sampling (eng_samp),
        .o_done     (eng_done),
        .o_result   (eng_result),
        .o_trial    (eng_trial)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_comb begin
        // RULE7 writes ignored in STOP
        wr_ctrl1  = reg_hit(i_wr, i_addr, OFS_CTRL1) && !i_stop;
        wr_ctrl2  = reg_hit(i_wr, i_addr, OFS_CTRL2) && !i_stop;
        start_req = wr_ctrl1 && i_wdata[START_BIT];
        refused   = start_req && (eng_busy || start_q);
        ctrl1_d   = ctrl1_q;
        ctrl2_d   = ctrl2_q;
        // RULE1 one-cycle start request
        start_d   = start_req && !refused;
        // RULE2 RULE3 channel and gate stored
        if (wr_ctrl1) begin
            ctrl1_d = {1'b0, i_wdata[6:0]};
        end
        // RULE8 RULE9 ladder and time stored
        if (wr_ctrl2) begin
            ctrl2_d = {2'h0, i_wdata[5:0]};
        end
        // RULE7 reset on STOP entry
        if (i_stop) begin
            ctrl1_d = RST_CTRL1;
            ctrl2_d = RST_CTRL2;
            start_d = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl1_q <= RST_CTRL1;
            ctrl2_q <= RST_CTRL2;
            start_q <= 1'b0;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            start_q <= start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result and end flag

    always_comb begin
        result_d = result_q;
        eoc_d    = eoc_q;
        // RULE14 read of result clears end flag
        if (reg_hit(i_rd, i_addr, OFS_RESULT)) begin
            eoc_d = 1'b0;
        end
        // RULE13 new start clears end flag
        if (start_q) begin
            eoc_d = 1'b0;
        end
        // RULE18 store result and set flag together
        if (eng_done) begin
            result_d = eng_result;
            eoc_d    = 1'b1;
        end
        if (i_stop) begin
            result_d = RST_RESULT;
            eoc_d    = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            // RULE12 result resets to zero
            result_q <= RST_RESULT;
            eoc_q    <= 1'b0;
        end else begin
            result_q <= result_d;
            eoc_q    <= eoc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    always_comb begin
        ev_set              = '0;
        // RULE18 completion interrupt event
        ev_set[IRQ_DONE]    = eng_done;
        ev_set[IRQ_REFUSED] = refused;
        imask_d = imask_q;
        istat_d = istat_q;
        if (reg_hit(i_wr, i_addr, OFS_IRQ_MASK)) begin
            imask_d = i_wdata[IRQ_W-1:0];
        end
        if (reg_hit(i_wr, i_addr, OFS_IRQ_STAT)) begin
            istat_d = istat_q & ~i_wdata[IRQ_W-1:0];
        end
        istat_d = istat_d | ev_set;
        irq_d   = |(istat_d & imask_d);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            istat_q <= RST_IRQ;
            imask_q <= RST_IRQ;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q   <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                OFS_CTRL1:    rdata_d = {start_q, ctrl1_q[6:0]};
                // RULE11 top bits of second control read zero
                OFS_CTRL2:    rdata_d = {2'h0, ctrl2_q[5:0]};
                OFS_RESULT:   rdata_d = result_q;
                // RULE16 RULE15 only end and busy meaningful
                OFS_STATUS:   rdata_d = {2'h0, eoc_q, eng_busy || start_q, 4'h0};
                OFS_IRQ_STAT: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, istat_q};
                OFS_IRQ_MASK: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, imask_q};
                default:      rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference ladder

    always_comb begin
        // RULE8 ladder only during conversion when set
        if (ctrl2_d[LADDER_BIT]) begin
            ladder_d = start_d || start_q || (eng_busy && !eng_done);
        end else begin
            ladder_d = 1'b1;
        end
        if (i_stop) begin
            ladder_d = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ladder_q <= 1'b1;
        end else begin
            ladder_q <= ladder_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_rdata          = rdata_q;
    assign o_irq            = irq_q;
    assign o_channel        = ctrl1_q[CH_LSB +: 4];
    assign o_input_gate_off = ctrl1_q[GATE_BIT];
    assign o_ladder_on      = ladder_q;
    assign o_sample         = eng_samp;
    assign o_dac_code       = eng_trial;
    // RULE15 busy from engine state
    assign o_busy           = eng_busy;

endmodule

// file: sar_engine.sv
`timescale 1ns/1ps
module sar_engine (
    // Clock and reset
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    // Control
    input  wire logic                        i_start,
    input  wire logic                        i_abort,
    input  wire logic [sar_adc_pkg::CNT_W-1:0] i_total,
    input  wire logic                        i_cmp,
    // Status and data
    output logic                             o_busy,
    output logic                             o_sampling,
    output logic                             o_done,
    output logic [7:0]                       o_result,
    output logic [7:0]                       o_trial
);
    import sar_adc_pkg::*;

    sar_state_t  st_q,    st_d;
    logic [8:0]  cnt_q,   cnt_d;
    logic [8:0]  step_q,  step_d;
    logic [8:0]  stepc_q, stepc_d;
    logic [2:0]  bit_q,   bit_d;
    logic [7:0]  code_q,  code_d;
    logic [7:0]  res_q,   res_d;
    logic        done_q,  done_d;
    logic        busy_q,  busy_d;
    logic        samp_q,  samp_d;
    logic [7:0]  decided;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        step_d  = step_q;
        stepc_d = stepc_q;
        bit_d   = bit_q;
        code_d  = code_q;
        res_d   = res_q;
        done_d  = 1'b0;
        decided = code_q;
        decided[bit_q] = i_cmp;
        if (i_abort) begin
            st_d   = ST_IDLE;
            code_d = 8'h00;
            res_d  = 8'h00;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // RULE19 load cycle count
                    if (i_start) begin
                        st_d   = ST_SAMPLE;
                        cnt_d  = i_total - 9'h001;
                        step_d = (i_total - SAMPLE_MIN) >> 3;
                        code_d = 8'h00;
                    end
                end
                ST_SAMPLE: begin
                    cnt_d = cnt_q - 9'h001;
                    if (cnt_q == {step_q[5:0], 3'h0}) begin
                        st_d    = ST_TRIAL;
                        code_d  = 8'h80;
                        bit_d   = 3'h7;
                        stepc_d = step_q - 9'h001;
                    end
                end
                ST_TRIAL: begin
                    cnt_d   = cnt_q - 9'h001;
                    stepc_d = stepc_q - 9'h001;
                    // RULE19 MSB first trials
                    if (stepc_q == 9'h000) begin
                        code_d  = decided;
                        stepc_d = step_q - 9'h001;
                        if (bit_q == 3'h0) begin
                            st_d   = ST_IDLE;
                            res_d  = decided;
                            done_d = 1'b1;
                        end else begin
                            code_d[bit_q - 3'h1] = 1'b1;
                            bit_d = bit_q - 3'h1;
                        end
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
        // Status outputs registered from the next state
        busy_d = (st_d != ST_IDLE);
        samp_d = (st_d == ST_SAMPLE);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 9'h000;
            step_q  <= 9'h000;
            stepc_q <= 9'h000;
            bit_q   <= 3'h0;
            code_q  <= 8'h00;
            res_q   <= 8'h00;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
            samp_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            step_q  <= step_d;
            stepc_q <= stepc_d;
            bit_q   <= bit_d;
            code_q  <= code_d;
            res_q   <= res_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
            samp_q  <= samp_d;
        end
    end

    assign o_busy     = busy_q;
    assign o_sampling = samp_q;
    assign o_done     = done_q;
    assign o_result   = res_q;
    assign o_trial    = code_q;

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sar_adc_pkg::*;
    logic        i_mclk      = 1'b0;
    logic        i_rst       = 1'b1;
    logic        i_stop      = 1'b0;
    logic [7:0]  i_addr      = 8'h00;
    logic [7:0]  i_wdata     = 8'h00;
    logic        i_wr        = 1'b0;
    logic        i_rd        = 1'b0;
    logic        i_cmp;
    logic [7:0]  o_rdata;
    logic        o_irq;
    logic [3:0]  o_channel;
    logic        o_input_gate_off;
    logic        o_ladder_on;
    logic        o_sample;
    logic [7:0]  o_dac_code;
    logic        o_busy;
    logic [7:0]  analog_v    = 8'h00;
    logic [7:0]  rd_v;
    int          cnt;
    int          miscompares = 0;
    int          cmp_count   = 0;

    always #12.5 i_mclk = ~i_mclk;
    assign i_cmp = (analog_v >= o_dac_code);

    sar_adc_register_control dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_stop(i_stop), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_cmp(i_cmp), .o_channel(o_channel), .o_input_gate_off(o_input_gate_off),
        .o_ladder_on(o_ladder_on), .o_sample(o_sample), .o_dac_code(o_dac_code),
        .o_busy(o_busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        rd_v = o_rdata;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic wait_idle;
        cnt = 0;
        while (o_busy === 1'b1 && cnt < 400) begin
            @(posedge i_mclk);
            #1;
            cnt++;
        end
        if (cnt >= 400) begin
            miscompares++;
            test_done;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic reset_vals;
        rd(OFS_CTRL1);
        chk(rd_v, 8'h10);
        rd(OFS_CTRL2);
        chk(rd_v & 8'h3f, 8'h10);
        rd(OFS_RESULT);
        chk(rd_v, 8'h00);
        rd(OFS_STATUS);
        chk(rd_v & 8'h30, 8'h00);
        rd(8'h40);
        chk(rd_v, 8'h00);
        chk({o_channel, 3'h0, o_input_gate_off}, 8'h01);
        wr(OFS_CTRL1, 8'h22);
        chk(o_input_gate_off, 1'b0);
        $display("reset values done");
    endtask

    task automatic conv(input logic [2:0] code, input logic [3:0] ch, input int n,
                        input logic [7:0] av);
        analog_v = av;
        wr(OFS_CTRL2, {4'h3, code, 1'b0});
        chk(o_ladder_on, 1'b0);
        wr(OFS_CTRL1, {4'ha, ch});
        chk({o_channel, o_sample, 1'b0, o_busy, o_ladder_on}, {ch, 4'hb});
        wait_idle;
        chk(16'(cnt), 16'(n));
        chk(o_sample, 1'b0);
        chk(o_irq, 1'b0);
        @(posedge i_mclk);
        #1;
        chk(o_irq, 1'b1);
        rd(OFS_STATUS);
        chk(rd_v & 8'h30, 8'h20);
        rd(OFS_CTRL1);
        chk(rd_v, {4'h2, ch});
        rd(OFS_RESULT);
        chk(rd_v, av);
        rd(OFS_STATUS);
        chk(rd_v & 8'h30, 8'h00);
        wr(OFS_IRQ_STAT, 8'h01);
        chk(o_irq, 1'b0);
        $display("conversion of %0d cycles done", n);
    endtask

    task automatic refused;
        analog_v = 8'h5a;
        wr(OFS_CTRL2, 8'h34);
        wr(OFS_CTRL1, 8'ha5);
        repeat (10) @(posedge i_mclk);
        #1;
        wr(OFS_CTRL1, 8'ha5);
        wait_idle;
        chk(16'(cnt), 16'd66);
        @(posedge i_mclk);
        #1;
        rd(OFS_IRQ_STAT);
        chk(rd_v, 8'h03);
        chk(o_irq, 1'b1);
        wr(OFS_IRQ_MASK, 8'h00);
        chk(o_irq, 1'b0);
        wr(OFS_IRQ_STAT, 8'h03);
        rd(OFS_IRQ_STAT);
        chk(rd_v, 8'h00);
        wr(OFS_IRQ_MASK, 8'h01);
        $display("refused restart done");
    endtask

    task automatic stop_mode;
        wr(OFS_CTRL2, 8'h38);
        wr(OFS_CTRL1, 8'ha3);
        repeat (5) @(posedge i_mclk);
        i_stop <= 1'b1;
        wr(OFS_CTRL1, 8'h25);
        chk({o_channel, o_busy, o_ladder_on, o_input_gate_off}, 7'h01);
        chk(o_dac_code, 8'h00);
        i_stop <= 1'b0;
        @(posedge i_mclk);
        #1;
        rd(OFS_CTRL1);
        chk(rd_v, 8'h10);
        rd(OFS_CTRL2);
        chk(rd_v & 8'h3f, 8'h10);
        rd(OFS_RESULT);
        chk(rd_v, 8'h00);
        rd(OFS_STATUS);
        chk(rd_v & 8'h30, 8'h00);
        $display("stop mode done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        reset_vals;
        wr(OFS_IRQ_MASK, 8'h01);
        conv(TIME_SHORT, 4'h2, 78, 8'h01);
        conv(TIME_MID, 4'h3, 156, 8'hff);
        conv(TIME_LONG, 4'h4, 312, 8'ha7);
        conv(3'h7, 4'h5, 312, 8'h3c);
        refused;
        stop_mode;
        test_done;
    end
endmodule
